// ---- core/mps_core.sv ----
// Mode control, protection flags and status framing behind the serial link
//
// Overview of operation
// - Writing the mode bit as one brings the device into active mode.
// - Writing the mode bit as zero enters standby and clears every control bit.
// - After power-on reset the device sits in standby until enabled.
// - Top status bit always reads one, so no valid frame is uniform.
// - Supply over- or undervoltage sets its flag and turns all outputs off.
// - Outputs come back by themselves once the supply is normal again.
// - Over-current sets that output's flag and switches that output off.
// - With recovery enabled the output retries after a delay set by duty bit.
// - With recovery disabled the output stays off until the controller writes flag-clear.
// - Thermal shutdown sets its flag and turns all outputs off.
// - Thermal flag holds outputs off until the controller writes flag-clear.
// - Temperature warning flag stays set until the controller clears it.
// - Standby to active starts the settling timer and sets not-ready.
// - Not-ready duration is counted on the internal clock.
// - Not-ready clears by itself when the settling time ends.
// - Bit 0 of each status word is NOR of bits 1 to 22 of both.
`timescale 1ns/100ps

module mps_core (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Serial link
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic mosi,
    output logic miso,
    // Supply and thermal detectors
    input wire logic load_supply_ov,
    input wire logic load_supply_uv,
    input wire logic thermal_shutdown_det,
    input wire logic temperature_warning_det,
    // Over-current detectors, bit 0 a, bit 1 b, bit 2 c
    input wire logic [2:0] overcurrent_det,
    // Switch requests from the output control word
    input wire logic [2:0] output_request,
    // High-side driver enables
    output logic highside_output_a,
    output logic highside_output_b,
    output logic highside_output_c
);

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: receive shift, frame counter, transmit bit

    logic [mps_pkg::CNT_W-1:0] bit_cnt_q;
    logic [mps_pkg::CNT_W-1:0] bit_cnt_d;
    logic [mps_pkg::FRAME_BITS-1:0] rx_shift_q;
    logic [mps_pkg::FRAME_BITS-1:0] rx_shift_d;
    logic frame_full_q;
    logic frame_full_d;
    logic miso_q;
    logic miso_d;
    logic [mps_pkg::FRAME_BITS-1:0] tx_hold_q;
    logic [mps_pkg::FRAME_BITS-1:0] tx_hold_d;

    always_comb begin
        bit_cnt_d = bit_cnt_q;
        rx_shift_d = rx_shift_q;
        frame_full_d = frame_full_q;
        // Bits beyond the twenty-fourth are ignored
        if (bit_cnt_q < mps_pkg::FRAME_DONE) begin
            rx_shift_d = {rx_shift_q[mps_pkg::FRAME_BITS-2:0], mosi};
            bit_cnt_d = bit_cnt_q + 5'h01;
        end
        if (bit_cnt_q == 5'h00) begin
            frame_full_d = 1'b0;
        end
        if (bit_cnt_q == mps_pkg::FRAME_LAST) begin
            frame_full_d = 1'b1;
        end
    end

    // Counter restarts with every frame select
    always_ff @(posedge sclk or posedge cs_b) begin
        if (cs_b) begin
            bit_cnt_q <= 5'h00;
        end else begin
            bit_cnt_q <= bit_cnt_d;
        end
    end

    // Received data only, qualified by the frame flag
    always_ff @(posedge sclk) begin
        rx_shift_q <= rx_shift_d;
    end

    // Frame flag outlives select so the system side can see it
    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            frame_full_q <= 1'b0;
        end else begin
            frame_full_q <= frame_full_d;
        end
    end

    always_comb begin
        miso_d = 1'b0;
        if (bit_cnt_q < mps_pkg::FRAME_DONE) begin
            miso_d = tx_hold_q[5'(mps_pkg::FRAME_LAST - bit_cnt_q)];
        end
    end

    // frame marker first
    // Idle level is the always-one top bit, ready before the first edge
    always_ff @(negedge sclk or posedge cs_b) begin
        if (cs_b) begin
            miso_q <= mps_pkg::MISO_IDLE;
        end else begin
            miso_q <= miso_d;
        end
    end

    assign miso = miso_q;

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers into the system domain

    logic cs_s1_q;
    logic cs_s2_q;
    logic cs_s3_q;
    logic full_s1_q;
    logic full_s2_q;
    mps_pkg::mps_fault_t fault_raw;
    mps_pkg::mps_fault_t fault_s1_q;
    mps_pkg::mps_fault_t fault_s2_q;

    assign fault_raw = {load_supply_ov, load_supply_uv, thermal_shutdown_det,
                        temperature_warning_det, overcurrent_det};

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            full_s1_q <= 1'b0;
            full_s2_q <= 1'b0;
            fault_s1_q <= '0;
            fault_s2_q <= '0;
        end else begin
            cs_s1_q <= cs_b;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            full_s1_q <= frame_full_q;
            full_s2_q <= full_s1_q;
            fault_s1_q <= fault_raw;
            fault_s2_q <= fault_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame decode and control word

    logic frame_take;
    logic flag_clear;
    mps_pkg::mps_ctrl_t ctrl_q;
    mps_pkg::mps_ctrl_t ctrl_d;
    logic rd_sel_q;
    logic rd_sel_d;

    // Select rising with a complete frame behind it
    assign frame_take = cs_s2_q & ~cs_s3_q & full_s2_q;

    always_comb begin
        ctrl_d = ctrl_q;
        rd_sel_d = rd_sel_q;
        flag_clear = 1'b0;
        if (frame_take) begin
            rd_sel_d = rx_shift_q[mps_pkg::REG_SEL_BIT];
            if (rx_shift_q[mps_pkg::REG_SEL_BIT]) begin
                ctrl_d = rx_shift_q;
                // standby clears all
                // Mode bit low wipes the whole control word
                if (!rx_shift_q[mps_pkg::FLAG_CLEAR_BIT]) begin
                    ctrl_d = mps_pkg::CTRL_RESET;
                end
            end else begin
                flag_clear = rx_shift_q[mps_pkg::FLAG_CLEAR_BIT];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ctrl_q <= mps_pkg::CTRL_RESET;
            rd_sel_q <= mps_pkg::RD_SEL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
            rd_sel_q <= rd_sel_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode state machine with settling timer

    mps_pkg::mps_mode_t mode_q;
    mps_pkg::mps_mode_t mode_d;
    logic [mps_pkg::TIMER_W-1:0] settle_q;
    logic [mps_pkg::TIMER_W-1:0] settle_d;
    logic not_ready;

    always_comb begin
        mode_d = mode_q;
        settle_d = settle_q;
        case (mode_q)
            mps_pkg::MPS_STANDBY: begin
                if (ctrl_q.enable) begin
                    mode_d = mps_pkg::MPS_SETTLE;
                    settle_d = mps_pkg::SETTLE_CYCLES;
                end
            end
            mps_pkg::MPS_SETTLE: begin
                if (!ctrl_q.enable) begin
                    mode_d = mps_pkg::MPS_STANDBY;
                    settle_d = mps_pkg::TIMER_ZERO;
                end else if (settle_q == mps_pkg::TIMER_ONE) begin
                    mode_d = mps_pkg::MPS_ACTIVE;
                    settle_d = mps_pkg::TIMER_ZERO;
                end else begin
                    settle_d = settle_q - mps_pkg::TIMER_ONE;
                end
            end
            mps_pkg::MPS_ACTIVE: begin
                if (!ctrl_q.enable) begin
                    mode_d = mps_pkg::MPS_STANDBY;
                end
            end
            default: begin
                mode_d = mps_pkg::MPS_STANDBY;
                settle_d = mps_pkg::TIMER_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            mode_q <= mps_pkg::MPS_STANDBY;
            settle_q <= mps_pkg::TIMER_ZERO;
        end else begin
            mode_q <= mode_d;
            settle_q <= settle_d;
        end
    end

    assign not_ready = (mode_q == mps_pkg::MPS_SETTLE);

    ////////////////////////////////////////////////////////////////////////////
    // Sticky thermal flags

    logic thermal_q;
    logic thermal_d;
    logic warning_q;
    logic warning_d;

    always_comb begin
        thermal_d = fault_s2_q.thermal | (thermal_q & ~flag_clear);
        warning_d = fault_s2_q.warning | (warning_q & ~flag_clear);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            thermal_q <= 1'b0;
            warning_q <= 1'b0;
        end else begin
            thermal_q <= thermal_d;
            warning_q <= warning_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-output over-current handling and drivers

    logic drive_ok;
    logic [2:0] recover_en;
    wire [2:0] oc_flag;
    wire [2:0] drive;

    assign drive_ok = (mode_q == mps_pkg::MPS_ACTIVE) & ~fault_s2_q.overvolt
                      & ~fault_s2_q.undervolt & ~thermal_q;
    assign recover_en = {ctrl_q.recover_c, ctrl_q.recover_b, ctrl_q.recover_a};

    function automatic logic [mps_pkg::TIMER_W-1:0] retry_cycles(input logic duty_long);
        retry_cycles = duty_long ? mps_pkg::RETRY_LONG_CYCLES : mps_pkg::RETRY_SHORT_CYCLES;
    endfunction

    genvar ch;
    generate
        for (ch = 0; ch < 3; ch++) begin : g_chan
            logic flag_q;
            logic flag_d;
            logic off_q;
            logic off_d;
            logic drv_q;
            logic drv_d;
            logic oc_event;
            logic [mps_pkg::TIMER_W-1:0] wait_q;
            logic [mps_pkg::TIMER_W-1:0] wait_d;

            assign oc_event = fault_s2_q.overcurrent[ch] & drv_q;

            always_comb begin
                flag_d = flag_q;
                off_d = off_q;
                wait_d = wait_q;
                if (oc_event) begin
                    flag_d = 1'b1;
                    off_d = 1'b1;
                    wait_d = retry_cycles(ctrl_q.duty_long);
                end else begin
                    if (flag_clear) begin
                        flag_d = 1'b0;
                        off_d = 1'b0;
                    end
                    if (off_q && wait_q != mps_pkg::TIMER_ZERO) begin
                        wait_d = wait_q - mps_pkg::TIMER_ONE;
                    end else if (off_q && recover_en[ch]) begin
                        off_d = 1'b0;
                    end
                end
                drv_d = drive_ok & output_request[ch] & ~off_q & ~oc_event;
            end

            always_ff @(posedge clk_sys) begin
                if (!rst_b) begin
                    flag_q <= 1'b0;
                    off_q <= 1'b0;
                    drv_q <= 1'b0;
                    wait_q <= mps_pkg::TIMER_ZERO;
                end else begin
                    flag_q <= flag_d;
                    off_q <= off_d;
                    drv_q <= drv_d;
                    wait_q <= wait_d;
                end
            end

            assign oc_flag[ch] = flag_q;
            assign drive[ch] = drv_q;
        end
    endgenerate

    assign highside_output_a = drive[0];
    assign highside_output_b = drive[1];
    assign highside_output_c = drive[2];

    ////////////////////////////////////////////////////////////////////////////
    // Status words and transmit snapshot

    logic [mps_pkg::FRAME_BITS-1:0] status0;
    logic [mps_pkg::FRAME_BITS-1:0] status1;
    logic no_error;

    always_comb begin
        status0 = '0;
        status1 = '0;
        status0[mps_pkg::ST_FRAME_MARK] = 1'b1;
        status1[mps_pkg::ST_FRAME_MARK] = 1'b1;
        status1[mps_pkg::ST1_OVERVOLT] = fault_s2_q.overvolt;
        status1[mps_pkg::ST1_UNDERVOLT] = fault_s2_q.undervolt;
        status1[mps_pkg::ST1_THERMAL] = thermal_q;
        status1[mps_pkg::ST1_WARNING] = warning_q;
        status1[mps_pkg::ST1_NOT_READY] = not_ready;
        status0[mps_pkg::ST0_OC_A] = oc_flag[0];
        status0[mps_pkg::ST0_OC_B] = oc_flag[1];
        status0[mps_pkg::ST0_OC_C] = oc_flag[2];
        no_error = ~(|status0[mps_pkg::ST_ERR_HI:mps_pkg::ST_ERR_LO]
                     | |status1[mps_pkg::ST_ERR_HI:mps_pkg::ST_ERR_LO]);
        status0[mps_pkg::ST_NO_ERROR] = no_error;
        status1[mps_pkg::ST_NO_ERROR] = no_error;
        // Snapshot frozen while a frame runs
        tx_hold_d = tx_hold_q;
        if (cs_s2_q) begin
            tx_hold_d = rd_sel_q ? status1 : status0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            tx_hold_q <= mps_pkg::STATUS_RESET;
        end else begin
            tx_hold_q <= tx_hold_d;
        end
    end

endmodule

// ---- core/mps_pkg.sv ----
// Constants, field layouts and carrier types of the mode and protection status block
package mps_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Frame geometry
    localparam int FRAME_BITS = 24;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] FRAME_LAST = 5'h17;
    localparam logic [CNT_W-1:0] FRAME_DONE = 5'h18;
    localparam int REG_SEL_BIT = 0;
    localparam int FLAG_CLEAR_BIT = 23;

    ////////////////////////////////////////////////////////////////////////////
    // Status word bit positions
    localparam int ST_FRAME_MARK = 23;
    localparam int ST1_OVERVOLT = 22;
    localparam int ST1_UNDERVOLT = 21;
    localparam int ST1_THERMAL = 20;
    localparam int ST1_WARNING = 19;
    localparam int ST1_NOT_READY = 18;
    localparam int ST0_OC_A = 14;
    localparam int ST0_OC_B = 15;
    localparam int ST0_OC_C = 17;
    localparam int ST_NO_ERROR = 0;
    localparam int ST_ERR_LO = 1;
    localparam int ST_ERR_HI = 22;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [FRAME_BITS-1:0] CTRL_RESET = 24'h000000;
    localparam logic [FRAME_BITS-1:0] STATUS_RESET = 24'h800001;
    localparam logic MISO_IDLE = 1'b1;
    localparam logic RD_SEL_RESET = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_FREQ_MHZ = 125;
    localparam int SETTLE_TIME_US = 32;
    localparam int RETRY_SHORT_US = 8;
    localparam int RETRY_LONG_US = 32;
    localparam int TIMER_W = 12;
    localparam logic [TIMER_W-1:0] SETTLE_CYCLES = TIMER_W'(SETTLE_TIME_US * CLK_FREQ_MHZ);
    localparam logic [TIMER_W-1:0] RETRY_SHORT_CYCLES = TIMER_W'(RETRY_SHORT_US * CLK_FREQ_MHZ);
    localparam logic [TIMER_W-1:0] RETRY_LONG_CYCLES = TIMER_W'(RETRY_LONG_US * CLK_FREQ_MHZ);
    localparam logic [TIMER_W-1:0] TIMER_ZERO = 12'h000;
    localparam logic [TIMER_W-1:0] TIMER_ONE = 12'h001;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [2:0] {
        MPS_STANDBY = 3'b001,
        MPS_SETTLE = 3'b010,
        MPS_ACTIVE = 3'b100
    } mps_mode_t;

    // Written mode and recovery control word
    typedef struct packed {
        logic enable;
        logic recover_c;
        logic duty_long;
        logic recover_b;
        logic recover_a;
        logic spare18;
        logic [17:0] lower;
    } mps_ctrl_t;

    // Detector levels after synchronisation
    typedef struct packed {
        logic overvolt;
        logic undervolt;
        logic thermal;
        logic warning;
        logic [2:0] overcurrent;
    } mps_fault_t;

    localparam int FAULT_W = 7;

endpackage

// ---- tb/mps_checker.sv ----
// Port assertions for the mode and protection core
`timescale 1ns/100ps

module mps_checker (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Link
    input wire logic cs_b,
    input wire logic miso,
    // Detectors and requests
    input wire logic load_supply_ov,
    input wire logic load_supply_uv,
    input wire logic thermal_shutdown_det,
    input wire logic [2:0] overcurrent_det,
    input wire logic [2:0] output_request,
    // Drivers
    input wire logic highside_output_a,
    input wire logic highside_output_b,
    input wire logic highside_output_c
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    logic [2:0] drv;
    assign drv = {highside_output_c, highside_output_b, highside_output_a};

    ////////////////////////////////////////////////////////////////////////////
    ov_off_a: assert property (load_supply_ov [*5] |-> drv == 3'h0)
        else $error("drivers on during overvoltage");
    uv_off_a: assert property (load_supply_uv [*5] |-> drv == 3'h0)
        else $error("drivers on during undervoltage");
    hot_off_a: assert property (thermal_shutdown_det [*5] |-> drv == 3'h0)
        else $error("drivers on during thermal shutdown");
    oc_off_a: assert property ($rose(overcurrent_det[0]) ##1 overcurrent_det[0] [*3] |=> !highside_output_a)
        else $error("driver a on after over-current");
    req_gate_a: assert property ((drv & ~$past(output_request)) == 3'h0)
        else $error("driver on without request");
    reset_off_a: assert property ($rose(rst_b) |-> drv == 3'h0 ##1 drv == 3'h0)
        else $error("driver on after reset");
    miso_idle_a: assert property (cs_b [*2] |-> miso)
        else $error("serial out low while idle");
    miso_mark_a: assert property ($fell(cs_b) |-> miso ##1 miso)
        else $error("frame marker bit not one");

    ////////////////////////////////////////////////////////////////////////////
    ov_seen_c: cover property (load_supply_ov [*5]);
    oc_seen_c: cover property ($rose(overcurrent_det[0]));
    frame_seen_c: cover property ($fell(cs_b));
endmodule

bind mps_core mps_checker u_chk (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .cs_b(cs_b),
    .miso(miso),
    .load_supply_ov(load_supply_ov),
    .load_supply_uv(load_supply_uv),
    .thermal_shutdown_det(thermal_shutdown_det),
    .overcurrent_det(overcurrent_det),
    .output_request(output_request),
    .highside_output_a(highside_output_a),
    .highside_output_b(highside_output_b),
    .highside_output_c(highside_output_c)
);

// ---- tb/mps_spi_master.sv ----
// Serial master model standing in for the controller
`timescale 1ns/100ps

module mps_spi_master (
    // Link
    output logic sclk,
    output logic cs_b,
    output logic mosi,
    input wire logic miso,
    // Uniform frames seen
    output int lost_count
);
    initial begin
        sclk = 1'b0;
        cs_b = 1'b1;
        mosi = 1'b0;
        lost_count = 0;
    end

    // One frame, MSB first, 12 ns link period, clock still outside frames
    task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
        #1.7;
        cs_b = 1'b0;
        mosi = tx[23];
        #40;
        for (int i = 23; i >= 0; i--) begin
            mosi = tx[i];
            #6;
            sclk = 1'b1;
            rx[i] = miso;
            #6;
            sclk = 1'b0;
        end
        #6;
        cs_b = 1'b1;
        mosi = ~mosi;
        if (rx === 24'h000000 || rx === 24'hFFFFFF) begin
            lost_count++;
        end
    endtask
endmodule

// ---- tb/test_mode_and_protection_status.sv ----
// Self-checking bench for the mode and protection core
`timescale 1ns/100ps

`define CHK(name, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("BAD %s exp %h got %h", name, exp, got); \
        end \
    end

module test_mode_and_protection_status;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic sclk, cs_b, mosi, miso;
    logic load_supply_ov = 1'b0;
    logic load_supply_uv = 1'b0;
    logic thermal_shutdown_det = 1'b0;
    logic temperature_warning_det = 1'b0;
    logic [2:0] overcurrent_det = 3'h0;
    logic [2:0] output_request = 3'h7;
    logic highside_output_a, highside_output_b, highside_output_c;
    logic [2:0] drv;
    logic [23:0] rx;
    int lost_count;
    int err_count = 0;
    int check_count = 0;

    assign drv = {highside_output_c, highside_output_b, highside_output_a};

    always #4 clk_sys = ~clk_sys;

    mps_core DUT (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .sclk(sclk),
        .cs_b(cs_b),
        .mosi(mosi),
        .miso(miso),
        .load_supply_ov(load_supply_ov),
        .load_supply_uv(load_supply_uv),
        .thermal_shutdown_det(thermal_shutdown_det),
        .temperature_warning_det(temperature_warning_det),
        .overcurrent_det(overcurrent_det),
        .output_request(output_request),
        .highside_output_a(highside_output_a),
        .highside_output_b(highside_output_b),
        .highside_output_c(highside_output_c)
    );

    mps_spi_master M (
        .sclk(sclk),
        .cs_b(cs_b),
        .mosi(mosi),
        .miso(miso),
        .lost_count(lost_count)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Frame out, answer compared, then an idle gap
    task automatic frame(input logic [23:0] tx, input logic [23:0] exp);
        M.xfer(tx, rx);
        `CHK("status", exp, rx)
        repeat (20) @(negedge clk_sys);
    endtask

    task automatic wait_chk(input int n, input logic [2:0] exp);
        repeat (n) @(negedge clk_sys);
        `CHK("drivers", exp, drv)
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(negedge clk_sys);
        rst_b = 1'b1;
        wait_chk(4, 3'h0);
        frame(24'hD80001, 24'h800001);
        frame(24'hD80001, 24'h840000);
        wait_chk(3800, 3'h0);
        wait_chk(200, 3'h7);
        for (int k = 0; k < 2; k++) begin
            {load_supply_ov, load_supply_uv} = (k == 0) ? 2'b10 : 2'b01;
            wait_chk(6, 3'h0);
            frame(24'hD80001, (k == 0) ? 24'hC00000 : 24'hA00000);
            {load_supply_ov, load_supply_uv} = 2'b00;
            wait_chk(6, 3'h7);
        end
        output_request = 3'h3;
        wait_chk(3, 3'h3);
        output_request = 3'h7;
        overcurrent_det = 3'h1;
        wait_chk(6, 3'h6);
        overcurrent_det = 3'h0;
        frame(24'h000000, 24'h800000);
        frame(24'h000000, 24'h804000);
        wait_chk(700, 3'h6);
        wait_chk(300, 3'h7);
        frame(24'h800000, 24'h804000);
        frame(24'hD80001, 24'h800001);
        thermal_shutdown_det = 1'b1;
        temperature_warning_det = 1'b1;
        wait_chk(6, 3'h0);
        thermal_shutdown_det = 1'b0;
        temperature_warning_det = 1'b0;
        wait_chk(100, 3'h0);
        frame(24'hD80001, 24'h980000);
        frame(24'h800000, 24'h980000);
        wait_chk(4, 3'h7);
        frame(24'hD80001, 24'h800001);
        frame(24'h000001, 24'h800001);
        wait_chk(4, 3'h0);
        frame(24'h800001, 24'h800001);
        frame(24'h800001, 24'h840000);
        wait_chk(4000, 3'h7);
        frame(24'hE00001, 24'h800001);
        overcurrent_det = 3'h6;
        wait_chk(6, 3'h1);
        overcurrent_det = 3'h0;
        frame(24'h000000, 24'h800000);
        wait_chk(3000, 3'h1);
        wait_chk(1100, 3'h5);
        frame(24'h000000, 24'h828000);
        frame(24'h800000, 24'h828000);
        wait_chk(4, 3'h7);
        `CHK("lost", 0, lost_count)
        test_done();
    end

    initial begin
        repeat (40000) @(posedge clk_sys);
        err_count++;
        test_done();
    end
endmodule
